// ==== logic/pwa_pkg.sv ====
// Purpose: Constants for the group A prescale, width and status block
// Assumes: 16-bit registers on a plain strobe port
// Notes:   Offsets are word indices on the local register port
package pwa_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    localparam int          CHAN_N        = 3;
    localparam int          CNT_W         = 16;
    // Register offsets
    localparam logic [3:0]  OFS_CSR0      = 4'h0;
    localparam logic [3:0]  OFS_CTRL      = 4'h1;
    localparam logic [3:0]  OFS_COUNT0    = 4'h2;
    localparam logic [3:0]  OFS_IRQ_STAT  = 4'h5;
    localparam logic [3:0]  OFS_IRQ_MASK  = 4'h6;
    // First register fields
    localparam int          PRE_LSB       = 0;
    localparam int          CKSRC_BIT     = 3;
    localparam int          WID_LSB       = 4;
    localparam int          LOADED_LSB    = 10;
    localparam int          ERR_LSB       = 13;
    // Second register fields
    localparam int          EN_LSB        = 0;
    localparam int          IE_LSB        = 3;
    localparam int          CAR_LSB       = 6;
    localparam int          POL_LSB       = 9;
    localparam int          EIE_BIT       = 15;
    localparam logic [15:0] CTRL_MASK     = 16'h8fff;
    // Reset values
    localparam logic [2:0]  PRE_RST       = 3'h0;
    localparam logic [2:0]  WID_RST       = 3'h0;
    localparam logic [2:0]  LOADED_RST    = 3'h7;
    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    // Interrupt status layout: loaded events 0-2, error events 3-5
    localparam int          IRQ_W         = 6;
endpackage : pwa_pkg

// ==== logic/pwa_prescale_ctrl.sv ====
// Purpose: Shared prescaler, data width and channel status for PWM group A
// Assumes: Pins are asynchronous and synchronised here; single core clock
// Notes:   Channel counters included so loaded and error flags have a source
//
// Contract
// - Prescale field divides selected prescaler clock by two to its value.
// - Prescale field resets to zero, divide by one.
// - Source bit set selects core clock over two, clear selects pin.
// - Source bit resets to zero, external pin.
// - Width field 0 gives 16 bits, each step one less, 7 gives 9.
// - Width field resets to zero, 16 bits.
// - Count data stays left aligned; narrow widths use top bits.
// - Bits 7 to 9 of first register read zero.
// - Per channel loaded flag sets when count moves into buffer.
// - Loaded flag clears when software writes channel count.
// - Loaded flags are set after reset.
// - Error flag sets on carrier edge before compare match.
// - Error flag clears when channel disabled and on reset.
// - Second register is read write channel control; bits 12 to 14 read zero.
// - Enabled channel runs; disabled channel held in its reset state.
// - Internal carrier asserts at each counter wrap, set by width.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pwa_prescale_ctrl
    import pwa_pkg::*;
#(
    parameter int NCH = pwa_pkg::CHAN_N
) (
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    input  wire logic                        softReset,
    input  wire logic [pwa_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [pwa_pkg::DATA_W-1:0]  regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [pwa_pkg::DATA_W-1:0]  regRdata,
    input  wire logic                        groupAExtClockPin,
    input  wire logic [2:0]                  carrierPin,
    output logic      [2:0]                  pwmOut,
    output logic                             irq
);
    import pwa_pkg::*;

    // Left-aligned mask of the active top bits for a width code
    function automatic logic [CNT_W-1:0] widthMask(input logic [2:0] code);
        widthMask = 16'hffff << code;
    endfunction : widthMask

    // Increment step on the counter so the active field wraps at its width
    function automatic logic [CNT_W-1:0] widthStep(input logic [2:0] code);
        widthStep = 16'h0001 << code;
    endfunction : widthStep

    logic [2:0]        preSel_reg;
    logic              clkSrc_reg;
    logic [2:0]        widSel_reg;
    logic [2:0]        loaded_reg;
    logic [2:0]        err_reg;
    logic [15:0]       ctrl_reg;
    logic [15:0]       count_reg [3];
    logic [15:0]       buffer_reg [3];
    logic [15:0]       counter_reg [3];
    logic [2:0]        matched_reg;
    logic [2:0]        pwm_reg;
    logic [IRQ_W-1:0]  irqStat_reg;
    logic [IRQ_W-1:0]  irqMask_reg;
    logic              irq_reg;
    logic [15:0]       rdata_reg;
    logic [6:0]        preCnt_reg;
    logic              coreDiv_reg;
    logic [1:0]        extSync_reg;
    logic              extPrev_reg;
    logic [1:0]        carSync0_reg;
    logic [1:0]        carSync1_reg;
    logic [1:0]        carSync2_reg;
    logic [2:0]        carPrev_reg;

    logic              rstAll;
    logic              wrCsr0;
    logic              wrCtrl;
    logic              wrIrqStat;
    logic              wrIrqMask;
    logic [2:0]        wrCount;
    logic              anyEnabled;
    logic              srcEdge;
    logic [6:0]        preLimit;
    logic              tick;
    logic [2:0]        enBits;
    logic [2:0]        intCar;
    logic [2:0]        polBits;
    logic [2:0]        carSync;
    logic [2:0]        carEdge;
    logic [2:0]        carrier;
    logic [2:0]        transfer;
    logic [2:0]        errEvent;
    logic [15:0]       actMask;
    logic [15:0]       step;
    logic [15:0]       csr0Read;
    logic [15:0]       readMux;

    // Address decode and shared reset
    assign rstAll     = !rstn || softReset;
    assign wrCsr0     = regWr && (regAddr == OFS_CSR0);
    assign wrCtrl     = regWr && (regAddr == OFS_CTRL);
    assign wrIrqStat  = regWr && (regAddr == OFS_IRQ_STAT);
    assign wrIrqMask  = regWr && (regAddr == OFS_IRQ_MASK);
    assign enBits     = ctrl_reg[EN_LSB +: 3];
    assign intCar     = ctrl_reg[CAR_LSB +: 3];
    assign polBits    = ctrl_reg[POL_LSB +: 3];
    assign anyEnabled = |enBits;
    assign actMask    = widthMask(widSel_reg);
    assign step       = widthStep(widSel_reg);
    assign carSync    = {carSync2_reg[1], carSync1_reg[1], carSync0_reg[1]};

    // Per-channel write strobes to the count registers
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gWr
            assign wrCount[g] = regWr && (regAddr == OFS_COUNT0 + 4'(g));
        end
    endgenerate

    // Prescaler source edge: core over two or synchronised pin rising edge
    assign srcEdge  = clkSrc_reg ? coreDiv_reg : (extSync_reg[1] && !extPrev_reg);
    assign preLimit = 7'(({1'b0, 7'h7f} >> (3'h7 - preSel_reg)));
    assign tick     = srcEdge && (preCnt_reg == preLimit);

    // Carrier edges and events per channel
    assign carEdge  = carSync & ~carPrev_reg;
    generate
        for (g = 0; g < 3; g++) begin : gCar
            assign carrier[g]  = intCar[g]
                ? (tick && ((counter_reg[g] | ~actMask) == 16'hffff))
                : carEdge[g];
            assign transfer[g] = enBits[g] && carrier[g];
            assign errEvent[g] = transfer[g] && !matched_reg[g] && pwm_reg[g]
                                 && (buffer_reg[g] != 16'h0000);
        end
    endgenerate

    // First register read image; bits 7-9 zero
    assign csr0Read = {err_reg, loaded_reg, 3'h0, widSel_reg, clkSrc_reg, preSel_reg};

    // Read selection
    assign readMux = (regAddr == OFS_CSR0)     ? csr0Read :
                     (regAddr == OFS_CTRL)     ? ctrl_reg :
                     (regAddr == OFS_COUNT0)   ? count_reg[0] :
                     (regAddr == OFS_COUNT0 + 4'h1) ? count_reg[1] :
                     (regAddr == OFS_COUNT0 + 4'h2) ? count_reg[2] :
                     (regAddr == OFS_IRQ_STAT) ? {10'h000, irqStat_reg} :
                     (regAddr == OFS_IRQ_MASK) ? {10'h000, irqMask_reg} : 16'h0000;

    // Pin synchronisers
    always_ff @(posedge core_clk) begin
        extSync_reg  <= {extSync_reg[0], groupAExtClockPin};
        carSync0_reg <= {carSync0_reg[0], carrierPin[0]};
        carSync1_reg <= {carSync1_reg[0], carrierPin[1]};
        carSync2_reg <= {carSync2_reg[0], carrierPin[2]};
        extPrev_reg  <= extSync_reg[1];
        carPrev_reg  <= carSync;
    end

    // Configuration fields of the first register
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            preSel_reg <= PRE_RST;
            clkSrc_reg <= 1'b0;
            widSel_reg <= WID_RST;
        end else if (wrCsr0) begin
            preSel_reg <= regWdata[PRE_LSB +: 3];
            clkSrc_reg <= regWdata[CKSRC_BIT];
            widSel_reg <= regWdata[WID_LSB +: 3];
        end
    end

    // Channel control register
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            ctrl_reg <= CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_reg <= regWdata & CTRL_MASK;
        end
    end

    // Prescaler counter and core divide by two
    always_ff @(posedge core_clk) begin
        if (rstAll || !anyEnabled) begin
            preCnt_reg  <= 7'h00;
            coreDiv_reg <= 1'b0;
        end else begin
            coreDiv_reg <= !coreDiv_reg;
            if (srcEdge) begin
                preCnt_reg <= (preCnt_reg == preLimit) ? 7'h00 : preCnt_reg + 7'h01;
            end
        end
    end

    // Per-channel count, buffer, counter, compare and output
    generate
        for (g = 0; g < 3; g++) begin : gCh
            always_ff @(posedge core_clk) begin
                if (rstAll) begin
                    count_reg[g] <= COUNT_RST;
                end else if (wrCount[g]) begin
                    count_reg[g] <= regWdata;
                end
            end
            always_ff @(posedge core_clk) begin
                if (rstAll || !enBits[g]) begin
                    buffer_reg[g]  <= COUNT_RST;
                    counter_reg[g] <= COUNT_RST;
                    matched_reg[g] <= 1'b0;
                    pwm_reg[g]     <= 1'b0;
                end else if (transfer[g]) begin
                    buffer_reg[g]  <= count_reg[g] & actMask;
                    counter_reg[g] <= COUNT_RST;
                    matched_reg[g] <= 1'b0;
                    pwm_reg[g]     <= (count_reg[g] & actMask) != 16'h0000;
                end else if (tick) begin
                    counter_reg[g] <= counter_reg[g] + step;
                    if (((counter_reg[g] + step) & actMask) == buffer_reg[g]) begin
                        matched_reg[g] <= 1'b1;
                        pwm_reg[g]     <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Status flags: hardware set wins over the clear
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            loaded_reg <= LOADED_RST;
            err_reg    <= 3'h0;
        end else begin
            loaded_reg <= transfer | (loaded_reg & ~wrCount);
            err_reg    <= errEvent | (err_reg & enBits);
        end
    end

    // Interrupt status, mask and output
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            irqStat_reg <= '0;
            irqMask_reg <= '0;
            irq_reg     <= 1'b0;
        end else begin
            irqStat_reg <= {errEvent, transfer}
                           | (irqStat_reg & ~(wrIrqStat ? regWdata[IRQ_W-1:0] : 6'h00));
            if (wrIrqMask) begin
                irqMask_reg <= regWdata[IRQ_W-1:0];
            end
            irq_reg <= |(irqStat_reg & irqMask_reg);
        end
    end

    // Read data one cycle after the strobe, outputs with polarity
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_reg <= 16'h0000;
            pwmOut    <= 3'h7;
        end else begin
            rdata_reg <= regRd ? readMux : 16'h0000;
            pwmOut    <= ~(pwm_reg ^ polBits);
        end
    end

    assign regRdata = rdata_reg;
    assign irq      = irq_reg;
endmodule : pwa_prescale_ctrl
`default_nettype wire

// ==== test/pwa_pins_model.sv ====
// Purpose: Far-side pins: prescaler clock pin and carrier pins
// Assumes: Rates are set in core clock cycles by the bench
// Notes:   Pin clock stands still while its half period is zero
`timescale 1ns/100ps
`default_nettype none
module pwa_pins_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] extHalf,
    input  wire logic [9:0] carPer,
    output wire logic       groupAExtClockPin,
    output wire logic [2:0] carrierPin
);
    int   extCnt = 0;
    int   carCnt = 0;
    logic extLvl = 1'b0;
    // Carrier is a 4-cycle pulse every carPer cycles
    assign carrierPin        = {3{carPer != 10'h000 && carCnt < 4}};
    assign groupAExtClockPin = extLvl;
    // Free counters; pin clock toggles every extHalf cycles
    always @(posedge core_clk) begin
        extCnt <= (extCnt + 1 >= extHalf) ? 0 : extCnt + 1;
        carCnt <= (carCnt + 1 >= carPer) ? 0 : carCnt + 1;
        extLvl <= (extHalf == 8'h00) ? 1'b0 : extLvl ^ (extCnt + 1 >= extHalf);
    end
endmodule : pwa_pins_model
`default_nettype wire

// ==== test/pwa_prescale_ctrl_sva.sv ====
// Purpose: Port checks for the group A prescale block
// Assumes: One clock, synchronous active-low reset
// Notes:   Shadows of written fields tie reads to writes
`timescale 1ns/100ps
`default_nettype none
module pwa_prescale_ctrl_sva
    import pwa_pkg::*;
#(
    parameter int NCH = pwa_pkg::CHAN_N
) (
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire logic              softReset,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              groupAExtClockPin,
    input wire logic [2:0]        carrierPin,
    input wire logic [2:0]        pwmOut,
    input wire logic              irq
);
    logic [15:0] ctrlReg;
    logic [6:0]  csrReg;
    logic [5:0]  maskReg;
    wire         rdCsr = regRd && regAddr == OFS_CSR0;
    // Shadow of writable fields
    always_ff @(posedge core_clk) begin
        if (!rstn || softReset) begin
            ctrlReg <= CTRL_RST;
            csrReg  <= 7'h00;
            maskReg <= 6'h00;
        end else if (regWr) begin
            ctrlReg <= (regAddr == OFS_CTRL) ? regWdata & CTRL_MASK : ctrlReg;
            csrReg  <= (regAddr == OFS_CSR0) ? regWdata[6:0] : csrReg;
            maskReg <= (regAddr == OFS_IRQ_MASK) ? regWdata[5:0] : maskReg;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_csr_read_back: assert property ($past(rdCsr) |-> regRdata[9:0] == {3'h0, $past(csrReg)})
        else $error("CSR0 low fields differ");
    a_ctrl_read_back: assert property ($past(regRd && regAddr == OFS_CTRL) |-> regRdata == $past(ctrlReg))
        else $error("control read differs");
    a_flags_reset_val: assert property ($past(softReset, 2) && rdCsr |=> regRdata[15:10] == 6'h07)
        else $error("status flags wrong after reset");
    a_loaded_clear: assert property (regWr && regAddr == OFS_COUNT0 && !ctrlReg[0] ##2 rdCsr && !ctrlReg[0]
        |=> !regRdata[LOADED_LSB])
        else $error("loaded flag not cleared");
    a_err_clear: assert property (!ctrlReg[0] && $past(!ctrlReg[0]) && rdCsr |=> !regRdata[ERR_LSB])
        else $error("error flag kept while disabled");
    a_idle_output: assert property (!ctrlReg[0] && $stable(ctrlReg) && $past(ctrlReg, 2) == ctrlReg
        |-> pwmOut[0] != ctrlReg[POL_LSB])
        else $error("disabled output not idle");
    a_irq_masked: assert property ($past(maskReg == 6'h00) |-> !irq)
        else $error("irq with mask clear");
    a_unmapped_zero: assert property (!$past(regRd && regAddr <= OFS_IRQ_MASK) |-> regRdata == 16'h0000)
        else $error("read data not zero");
endmodule : pwa_prescale_ctrl_sva
bind pwa_prescale_ctrl pwa_prescale_ctrl_sva #(.NCH(NCH)) pwa_prescale_ctrl_sva_inst (.core_clk(core_clk),
    .rstn(rstn), .softReset(softReset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .groupAExtClockPin(groupAExtClockPin), .carrierPin(carrierPin), .pwmOut(pwmOut), .irq(irq));
`default_nettype wire

// ==== test/pwa_prescale_ctrl_tb.sv ====
// Purpose: Self-checking bench for the group A prescale block
// Assumes: 40 MHz core clock, pins driven by the pin model
// Notes:   Periods are measured on channel 0 output
`timescale 1ns/100ps
`default_nettype none
module pwa_prescale_ctrl_tb;
    import pwa_pkg::*;
    logic              core_clk  = 1'b0;
    logic              rstn      = 1'b0;
    logic              softReset = 1'b0;
    logic [ADDR_W-1:0] regAddr   = 4'h0;
    logic [DATA_W-1:0] regWdata  = 16'h0000;
    logic              regWr     = 1'b0;
    logic              regRd     = 1'b0;
    logic [7:0]        extHalf   = 8'h00;
    logic [9:0]        carPer    = 10'h000;
    logic [DATA_W-1:0] regRdata;
    logic [2:0]        pwmOut;
    logic [2:0]        carrierPin;
    logic              extPin;
    logic              irq;
    int                err_total = 0;
    int                checks_done = 0;
    pwa_prescale_ctrl #(.NCH(CHAN_N)) pwa_prescale_ctrl_inst (.core_clk(core_clk), .rstn(rstn),
        .softReset(softReset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .groupAExtClockPin(extPin), .carrierPin(carrierPin), .pwmOut(pwmOut), .irq(irq));
    pwa_pins_model pwa_pins_model_inst (.core_clk(core_clk), .extHalf(extHalf), .carPer(carPer),
        .groupAExtClockPin(extPin), .carrierPin(carrierPin));
    // Clock
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge core_clk);
        regWr    <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd   <= 1'b0;
        #1 chk(regRdata & m, exp);
        @(posedge core_clk);
    endtask : rdchk
    // High time, then full period, counted from a rising output
    task automatic pulse(output logic [15:0] hi, output logic [15:0] per);
        int k;
        k = 0;
        while (pwmOut[0] === 1'b1 && k < 9000) begin
            @(posedge core_clk);
            k++;
        end
        hi = k[15:0];
        while (pwmOut[0] !== 1'b1 && k < 9000) begin
            @(posedge core_clk);
            k++;
        end
        per = k[15:0];
    endtask : pulse
    task automatic t_regs;
        rdchk(OFS_CSR0, 16'hffff, 16'h1c00);
        wr(OFS_CSR0, 16'hffff);
        rdchk(OFS_CSR0, 16'hffff, 16'h1c7f);
        wr(OFS_CTRL, 16'hfff8);
        rdchk(OFS_CTRL, 16'hffff, 16'h8ff8);
        rdchk(4'hf, 16'hffff, 16'h0000);
        softReset <= 1'b1;
        @(posedge core_clk);
        softReset <= 1'b0;
        @(posedge core_clk);
        rdchk(OFS_CSR0, 16'hffff, 16'h1c00);
        rdchk(OFS_CTRL, 16'hffff, 16'h0000);
    endtask : t_regs
    task automatic t_period(input logic [2:0] pre, input logic src, input logic [15:0] want);
        logic [15:0] hi;
        logic [15:0] per;
        wr(OFS_CSR0, {9'h000, 3'h7, src, pre});
        wr(OFS_COUNT0, 16'h8000);
        wr(OFS_CTRL, 16'h0241);
        pulse(hi, per);
        pulse(hi, per);
        chk(per, want);
        chk((hi + 16'h0004) >> 3, want >> 4);
        rdchk(OFS_CSR0, 16'h0400, 16'h0400);
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_COUNT0, 16'h8000);
        rdchk(OFS_CSR0, 16'h0400, 16'h0000);
    endtask : t_period
    task automatic t_err;
        wr(OFS_CSR0, 16'h0078);
        wr(OFS_IRQ_MASK, 16'h0008);
        wr(OFS_COUNT0, 16'hffff);
        wr(OFS_CTRL, 16'h0201);
        carPer <= 10'h0c8;
        repeat (700) @(posedge core_clk);
        rdchk(OFS_CSR0, 16'h2400, 16'h2400);
        chk({15'h0000, irq}, 16'h0001);
        wr(OFS_IRQ_MASK, 16'h0000);
        rdchk(OFS_IRQ_STAT, 16'h0008, 16'h0008);
        chk({15'h0000, irq}, 16'h0000);
        carPer <= 10'h000;
        repeat (6) @(posedge core_clk);
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_IRQ_STAT, 16'h003f);
        rdchk(OFS_CSR0, 16'he000, 16'h0000);
        rdchk(OFS_IRQ_STAT, 16'h003f, 16'h0000);
    endtask : t_err
    task automatic wrap_up;
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_regs;
        t_period(3'h0, 1'b1, 16'h0400);
        t_period(3'h1, 1'b1, 16'h0800);
        extHalf <= 8'h04;
        t_period(3'h0, 1'b0, 16'h1000);
        extHalf <= 8'h00;
        t_err;
        wrap_up;
    end
    // Watchdog
    initial begin
        repeat (80000) @(posedge core_clk);
        err_total++;
        wrap_up;
    end
endmodule : pwa_prescale_ctrl_tb
`default_nettype wire
